// >>> pkg/pos_pkg.sv
// package for the per-port operation control and status register bank
package pos_pkg;

  // register indices inside one port's window; byte address is four times the index
  localparam logic [11:0] IDX_CTRL_ZERO = 12'h020;
  localparam logic [11:0] IDX_CTRL_ONE  = 12'h021;
  localparam logic [11:0] IDX_STATUS    = 12'h030;

  // split of a full register index into port number and in-port index
  localparam int IDX_PORT_LSB = 12;
  localparam int IDX_PORT_W   = 4;
  localparam int IDX_LOW_W    = 12;
  localparam int ADDR_WORD_LSB = 2;

  // port_operation_control_zero fields
  localparam int CTRL0_TAIL_BIT  = 2;
  localparam int CTRL0_SPLIT_LSB = 0;
  localparam int CTRL0_USED_W    = 3;

  // port_operation_control_one fields
  localparam int CTRL1_CLASS_LSB = 0;
  localparam int CTRL1_USED_W    = 2;

  // port_link_status fields
  localparam int STAT_SPEED_LSB  = 3;
  localparam int STAT_DUPLEX_BIT = 2;
  localparam int STAT_TXFC_BIT   = 1;
  localparam int STAT_RXFC_BIT   = 0;

  // bits of the external_mac_interface control registers that the status mirrors
  localparam int XC0_DUPLEX_BIT = 6;
  localparam int XC0_TXFC_BIT   = 5;
  localparam int XC0_SPEED_BIT  = 4;
  localparam int XC0_RXFC_BIT   = 3;
  localparam int XC1_SPEED_BIT  = 6;

  // reset values
  localparam logic [2:0] CTRL0_RST = 3'h0;
  localparam logic [1:0] CTRL1_RST = 2'h0;

  // axi4-lite responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // egress queue split modes
  typedef enum logic [1:0] {
    SPLIT_ONE  = 2'b00,
    SPLIT_TWO  = 2'b01,
    SPLIT_FOUR = 2'b10,
    SPLIT_RSVD = 2'b11
  } pos_split_e;

  // stream reservation participation
  typedef enum logic [1:0] {
    CLASS_NONE             = 2'b00,
    CLASS_STREAM_CLASS_ONE = 2'b01,
    CLASS_STREAM_CLASS_TWO = 2'b10,
    CLASS_RSVD             = 2'b11
  } pos_class_e;

  // link speed encoding
  typedef enum logic [1:0] {
    SPEED_10   = 2'b00,
    SPEED_100  = 2'b01,
    SPEED_1000 = 2'b10,
    SPEED_RSVD = 2'b11
  } pos_speed_e;

  // link state reported by an integrated phy
  typedef struct packed {
    logic link_up;      // link established
    logic speed_100;    // 1 = 100 Mb/s, 0 = 10 Mb/s
    logic full_duplex;  // duplex in effect
    logic neg_tx_fc;    // negotiation agreed transmit pause
    logic neg_rx_fc;    // negotiation agreed receive pause
  } pos_phy_stat_s;

  // configuration a port hands to the switch core
  typedef struct packed {
    logic       tail_tag;     // port is the host port
    pos_split_e queue_split;  // egress queue split
    pos_class_e stream_class; // stream reservation class
  } pos_port_cfg_s;

endpackage

// >>> sim/pos_regs_assertions.sv
// concurrent checks on the port operation register bank, bound to its top module
module pos_regs_chk
  import pos_pkg::*;
#(
  parameter int NUM_PORTS = 3,
  parameter int ADDR_W    = 18
) (
  input wire logic                                  aclk,
  input wire logic                                  aresetn,
  input wire logic                                  s_axi_arvalid,
  input wire logic                                  s_axi_arready,
  input wire logic [ADDR_W-1:0]                     s_axi_araddr,
  input wire logic                                  s_axi_rvalid,
  input wire logic [31:0]                           s_axi_rdata,
  input wire logic [7:0]                            mac_ctl_zero,
  input wire logic [7:0]                            mac_ctl_one,
  input wire logic [NUM_PORTS-1:0][1:0]             pkt_prio,
  input wire pos_pkg::pos_port_cfg_s [NUM_PORTS-1:0] port_cfg,
  input wire logic [NUM_PORTS-1:0][1:0]             egress_queue,
  input wire logic [NUM_PORTS-1:0]                  host_port_sel,
  input wire logic                                  host_port_multi
);
  timeunit 1ns;
  timeprecision 1ps;
  // status address of the mac port, the last port window
  localparam logic [ADDR_W-1:0] MAC_STAT = ADDR_W'({4'(NUM_PORTS), IDX_STATUS, 2'b00});
  logic [NUM_PORTS-1:0] tail_v;   // tail tag bits gathered from all ports
  logic                 mac_rd;   // status read of the mac port taken this edge

  // tail tag bits of all ports as one vector
  always_comb
  begin
    for (int p = 0; p < NUM_PORTS; p++)
      tail_v[p] = port_cfg[p].tail_tag;
  end
  assign mac_rd = s_axi_arvalid && s_axi_arready && (s_axi_araddr == MAC_STAT);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RDATA_RSVD_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:5] == 27'h0)
    else $error("reserved read bits not zero");
  AST_HOST_SEL: assert property ($stable(tail_v) |-> host_port_sel == tail_v)
    else $error("host port select does not follow tail tag bits");
  AST_HOST_MULTI: assert property ($stable(tail_v) |->
    host_port_multi == ($countones(tail_v) > 1))
    else $error("multiple host flag wrong");
  // status is taken at the address edge: compare with past inputs
  AST_MAC_SPEED: assert property (mac_rd |=>
    s_axi_rvalid && s_axi_rdata[4:3] == {$past(mac_ctl_one[6]), $past(mac_ctl_zero[4])})
    else $error("mac speed status not mirrored");
  AST_MAC_DUPLEX: assert property (mac_rd |=> s_axi_rdata[2] == $past(mac_ctl_zero[6]))
    else $error("mac duplex status not mirrored");
  AST_MAC_PAUSE: assert property (mac_rd |=>
    s_axi_rdata[1:0] == {$past(mac_ctl_zero[5]), $past(mac_ctl_zero[3])})
    else $error("mac pause status not mirrored");

  // queue is registered: judge it once split and priority held a cycle
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_queue
    AST_SINGLE_QUEUE: assert property (port_cfg[p].queue_split == SPLIT_ONE &&
      $stable(port_cfg[p].queue_split) |-> egress_queue[p] == 2'h0)
      else $error("single queue mode used a queue other than zero");
    AST_TWO_QUEUE: assert property (port_cfg[p].queue_split == SPLIT_TWO &&
      $stable(port_cfg[p].queue_split) && $stable(pkt_prio[p]) |->
      egress_queue[p] == {1'b0, pkt_prio[p][1]})
      else $error("two queue mapping wrong");
    AST_FOUR_QUEUE: assert property (port_cfg[p].queue_split == SPLIT_FOUR &&
      $stable(port_cfg[p].queue_split) && $stable(pkt_prio[p]) |->
      egress_queue[p] == pkt_prio[p])
      else $error("four queue mapping wrong");
  end

  cover property (host_port_multi);
  cover property (mac_rd);
  cover property (port_cfg[0].queue_split == SPLIT_FOUR && egress_queue[0] == 2'h3);
endmodule

bind pos_regs pos_regs_chk #(.NUM_PORTS(NUM_PORTS), .ADDR_W(ADDR_W)) pos_regs_chk_inst (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rdata, .mac_ctl_zero, .mac_ctl_one, .pkt_prio, .port_cfg, .egress_queue,
  .host_port_sel, .host_port_multi
);

// >>> sim/tb_pos_regs.sv
// self-checking bench for the port operation register bank
module tb_pos_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import pos_pkg::*;

  // one row: byte address, data written, value read back, response
  typedef struct packed {
    logic [17:0] a;
    logic [7:0]  d;
    logic [7:0]  q;
    logic [1:0]  rs;
  } pos_row_s;

  logic                  aclk, aresetn;               // clock and active low reset
  logic                  awvalid, wvalid, bready;     // write side of the master
  logic                  arvalid, rready;             // read side of the master
  logic                  awready, wready, bvalid, arready, rvalid;
  logic [17:0]           awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp;
  pos_phy_stat_s [1:0]   phy;                         // phy pins, ports 1 and 2
  logic [1:0][1:0]       adv;                         // advertised pause bits
  logic [7:0]            cz, co;                      // mac interface control
  logic [2:0][1:0]       prio;                        // packet priority per port
  pos_port_cfg_s [2:0]   cfg;
  logic [2:0][1:0]       eq;
  logic [2:0]            hsel;
  logic                  hmulti;
  logic [7:0]            v;
  logic [1:0]            r;
  int                    n_tests = 0;
  int                    n_mismatch = 0;
  int                    cyc = 0;
  logic [7:0]            mz [4] = '{8'h00, 8'h78, 8'h28, 8'h50};
  // plain write and read cases, including two unmapped places
  pos_row_s              rows [7] = '{
    '{18'h04080, 8'h07, 8'h07, RESP_OKAY}, '{18'h08080, 8'hfa, 8'h02, RESP_OKAY},
    '{18'h0c084, 8'hff, 8'h03, RESP_OKAY}, '{18'h04084, 8'h01, 8'h01, RESP_OKAY},
    '{18'h08084, 8'h02, 8'h02, RESP_OKAY}, '{18'h04000, 8'h55, 8'h00, RESP_SLVERR},
    '{18'h00080, 8'h55, 8'h00, RESP_SLVERR}};

  pos_regs pos_regs_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .phy_stat_pin(phy), .phy_adv_pause(adv),
    .mac_ctl_zero(cz), .mac_ctl_one(co), .pkt_prio(prio), .port_cfg(cfg),
    .egress_queue(eq), .host_port_sel(hsel), .host_port_multi(hmulti)
  );

  // 40 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ceiling far above the few hundred cycles needed
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      n_mismatch++;
      results();
    end
  end

  function automatic logic [17:0] adr(input int p, input logic [11:0] i);
    return {p[3:0], i, 2'b00};
  endfunction

  // queue expected for a split mode; reserved split behaves as one queue
  function automatic logic [1:0] exq(input logic [1:0] s, input logic [1:0] q);
    return (s == 2'h2) ? q : (s == 2'h1) ? {1'b0, q[1]} : 2'h0;
  endfunction

  function automatic logic [7:0] mexp();
    return {3'h0, co[6], cz[4], cz[6], cz[5], cz[3]};
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic done(input string t);
    $display("test %s finished, mismatches so far %0d", t, n_mismatch);
  endtask

  // readies are combinational: sample mid-cycle, act at the next edge
  task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [3:0] st,
                    output logic [1:0] rs);
    logic aw_ok, w_ok, b_ok;
    int   n;
    n = 0;
    b_ok = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok && n < 64)
    begin
      @(negedge aclk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      rs = bresp;
      n++;
      @(posedge aclk);
      if (aw_ok)
        awvalid <= 1'b0;
      if (w_ok)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!b_ok)
      n_mismatch++;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [17:0] a, output logic [7:0] d, output logic [1:0] rs);
    logic ar_ok, r_ok;
    int   n;
    n = 0;
    r_ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok && n < 64)
    begin
      @(negedge aclk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      d = rdata[7:0];
      rs = rresp;
      n++;
      @(posedge aclk);
      if (ar_ok)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!r_ok)
      n_mismatch++;
    @(posedge aclk);
  endtask

  // registered outputs are read mid-cycle once settled
  task automatic wait_out();
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    phy[0] = 5'b11111;
    phy[1] = 5'b00111;
    adv = {2'b11, 2'b01};
    {cz, co, prio} = '0;
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int p = 1; p <= 3; p++)
    begin
      rd(adr(p, IDX_CTRL_ZERO), v, r);
      chk("ctrl zero reset", 8'h00, v);
      rd(adr(p, IDX_CTRL_ONE), v, r);
      chk("ctrl one reset", 8'h00, v);
    end
    done("reset");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d, 4'hf, r);
      chk("write resp", {6'h0, rows[i].rs}, {6'h0, r});
      rd(rows[i].a, v, r);
      chk("read resp", {6'h0, rows[i].rs}, {6'h0, r});
      chk("read data", rows[i].q, v);
    end
    done("rows");
    // every split mode and class, priorities swept
    for (int s = 0; s < 4; s++)
    begin
      wr(adr(1, IDX_CTRL_ZERO), 8'(s), 4'h1, r);
      wr(adr(2, IDX_CTRL_ONE), 8'(s), 4'h1, r);
      for (int q = 0; q < 4; q++)
      begin
        prio <= {3{2'(q)}};
        wait_out();
        chk("queue", {6'h0, exq(2'(s), 2'(q))}, {6'h0, eq[0]});
        chk("class", 8'(s), {6'h0, cfg[1].stream_class});
        chk("split", 8'(s), {6'h0, cfg[0].queue_split});
        @(posedge aclk);
      end
    end
    done("queues");
    // two host ports at once is flagged, then cleared back to one
    wr(adr(3, IDX_CTRL_ZERO), 8'h04, 4'h1, r);
    wr(adr(1, IDX_CTRL_ZERO), 8'h04, 4'h1, r);
    wait_out();
    chk("host sel", 8'h05, {5'h0, hsel});
    chk("host multi", 8'h01, {7'h0, hmulti});
    @(posedge aclk);
    wr(adr(1, IDX_CTRL_ZERO), 8'h00, 4'he, r);
    rd(adr(1, IDX_CTRL_ZERO), v, r);
    chk("strobe off", 8'h04, v);
    wr(adr(1, IDX_CTRL_ZERO), 8'h00, 4'h1, r);
    wait_out();
    chk("host sel", 8'h04, {5'h0, hsel});
    chk("host multi", 8'h00, {7'h0, hmulti});
    @(posedge aclk);
    done("host");
    // phy status: link up with pause, link down, pause not advertised
    rd(adr(1, IDX_STATUS), v, r);
    chk("phy status", 8'h0f, v);
    rd(adr(2, IDX_STATUS), v, r);
    chk("phy link down", 8'h04, v);
    adv <= {2'b11, 2'b00};
    @(posedge aclk);
    rd(adr(1, IDX_STATUS), v, r);
    chk("phy no advert", 8'h0c, v);
    done("phy status");
    foreach (mz[i])
    begin
      cz <= mz[i];
      co <= mz[i] & 8'h40;
      @(posedge aclk);
      rd(adr(3, IDX_STATUS), v, r);
      chk("mac status", mexp(), v);
    end
    wr(adr(3, IDX_STATUS), 8'hff, 4'hf, r);
    chk("status write resp", {6'h0, RESP_OKAY}, {6'h0, r});
    rd(adr(3, IDX_STATUS), v, r);
    chk("status write", mexp(), v);
    done("mac status");
    results();
  end
endmodule

// >>> src/pos_regs.sv
// per-port operation control and link status registers behind an axi4-lite slave
//
// Behaviour
// RULE_01: tail tag bit marks port as host
// RULE_02: software enables tail tag on one port
// RULE_03: queue split selects one, two, four queues
// RULE_04: split zero puts everything in one queue
// RULE_05: stream field selects class none, one, two
// RULE_06: mac port speed mirrors interface control bits
// RULE_07: phy port speed reports actual link speed
// RULE_08: mac port duplex mirrors control bit six
// RULE_09: phy port duplex reports actual link duplex
// RULE_10: mac port tx pause mirrors control bit five
// RULE_11: mac port rx pause mirrors control bit three
// RULE_12: phy pause needs advertisement, link, negotiation
// RULE_13: reserved bits zero, status ignores writes
//
// Local design decision: register access over AXI4-Lite.
module pos_regs
  import pos_pkg::*;
#(
  parameter int NUM_PORTS = 3,  // last port is the external mac port
  parameter int ADDR_W    = 18  // enough for sixteen port windows of indices
) (
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  // axi4-lite write address
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire logic [ADDR_W-1:0]                    s_axi_awaddr,
  input  wire logic [2:0]                           s_axi_awprot,
  // axi4-lite write data
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  input  wire logic [31:0]                          s_axi_wdata,
  input  wire logic [3:0]                           s_axi_wstrb,
  // axi4-lite write response
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  output logic [1:0]                                s_axi_bresp,
  // axi4-lite read address
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  input  wire logic [ADDR_W-1:0]                    s_axi_araddr,
  input  wire logic [2:0]                           s_axi_arprot,
  // axi4-lite read data
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready,
  output logic [31:0]                               s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  // integrated phy link state, asynchronous pins
  input  wire pos_pkg::pos_phy_stat_s [NUM_PORTS-2:0] phy_stat_pin,
  // phy advertisement pause bits 11:10, same clock
  input  wire logic [NUM_PORTS-2:0][1:0]            phy_adv_pause,
  // external_mac_interface control registers, same clock
  input  wire logic [7:0]                           mac_ctl_zero,
  input  wire logic [7:0]                           mac_ctl_one,
  // priority of the packet being queued at each port
  input  wire logic [NUM_PORTS-1:0][1:0]            pkt_prio,
  // configuration to the switch core
  output pos_pkg::pos_port_cfg_s [NUM_PORTS-1:0]    port_cfg,
  output logic [NUM_PORTS-1:0][1:0]                 egress_queue,
  output logic [NUM_PORTS-1:0]                      host_port_sel,
  output logic                                      host_port_multi
);

  localparam int NPHY   = NUM_PORTS - 1;
  localparam int STAT_W = $bits(pos_phy_stat_s);

  // all state of the block apart from the phy synchroniser stages
  typedef struct packed {
    logic                           aw_seen;  // write address held
    logic [ADDR_W-1:0]              aw_addr;  // held write address
    logic                           w_seen;   // write data held
    logic [7:0]                     w_byte;   // low byte of held data
    logic                           w_lane;   // low byte lane was strobed
    logic                           bvalid;   // write response pending
    logic [1:0]                     bresp;    // write response code
    logic                           rvalid;   // read data pending
    logic [31:0]                    rdata;    // read data
    logic [1:0]                     rresp;    // read response code
    logic [NUM_PORTS-1:0][2:0]      ctrl0;    // tail tag and queue split
    logic [NUM_PORTS-1:0][1:0]      ctrl1;    // stream class
    logic [NUM_PORTS-1:0][1:0]      queue;    // registered queue choice
    logic [NUM_PORTS-1:0]           host;     // host port flags, one per port
    logic                           multi;    // more than one host port
  } pos_state_s;

  pos_state_s                   state_reg;  // registered state
  pos_state_s                   state_next; // next state
  pos_phy_stat_s [NPHY-1:0]     phy_stat;   // synchronised phy state
  logic [NPHY*STAT_W-1:0]       phy_flat;   // flat view for the synchroniser

  // phy state comes from another clock, so it passes two flops first
  pos_sync #(
    .W (NPHY*STAT_W)
  ) u_phy_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (phy_stat_pin),
    .q       (phy_flat)
  );

  assign phy_stat = phy_flat;

  // address split: port number and index inside the port window
  function automatic logic [IDX_PORT_W-1:0] addr_port(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:ADDR_WORD_LSB];
    return idx[IDX_PORT_LSB +: IDX_PORT_W];
  endfunction

  // index of a register within one port window
  function automatic logic [IDX_LOW_W-1:0] addr_low(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:ADDR_WORD_LSB];
    return idx[IDX_LOW_W-1:0];
  endfunction

  // status byte of a port; reserved bits stay zero
  function automatic logic [7:0] status_byte(
    input logic          is_phy,
    input pos_phy_stat_s st,
    input logic [1:0]    adv,
    input logic [7:0]    xc0,
    input logic [7:0]    xc1
  );
    logic [7:0] s;
    logic       fc_ok;
    s     = 8'h00; // RULE_13
    fc_ok = (adv != 2'h0) && st.link_up;
    if (is_phy)
    begin
      // phy port reports what the link really runs at
      s[STAT_SPEED_LSB +: 2] = st.speed_100 ? SPEED_100 : SPEED_10; // RULE_07
      s[STAT_DUPLEX_BIT]     = st.full_duplex;                        // RULE_09
      s[STAT_TXFC_BIT]       = fc_ok && st.neg_tx_fc;                 // RULE_12
      s[STAT_RXFC_BIT]       = fc_ok && st.neg_rx_fc;                 // RULE_12
    end
    else
    begin
      // mac port just reflects what software set on the interface
      s[STAT_SPEED_LSB + 1]  = xc1[XC1_SPEED_BIT];  // RULE_06
      s[STAT_SPEED_LSB]      = xc0[XC0_SPEED_BIT];  // RULE_06
      s[STAT_DUPLEX_BIT]     = xc0[XC0_DUPLEX_BIT]; // RULE_08
      s[STAT_TXFC_BIT]       = xc0[XC0_TXFC_BIT];   // RULE_10
      s[STAT_RXFC_BIT]       = xc0[XC0_RXFC_BIT];   // RULE_11
    end
    return s;
  endfunction

  // queue index for a packet priority under a split mode
  function automatic logic [1:0] queue_of(
    input logic [1:0] split,
    input logic [1:0] prio
  );
    logic [1:0] q;
    q = 2'h0;
    unique case (split)
      SPLIT_ONE:  q = 2'h0;             // RULE_04
      SPLIT_TWO:  q = {1'b0, prio[1]};  // RULE_03
      SPLIT_FOUR: q = prio;             // RULE_03
      SPLIT_RSVD: q = 2'h0;             // reserved falls back to one queue
    endcase
    return q;
  endfunction

  // handshake outputs: a new item is only taken while no answer is owed
  assign s_axi_awready = !state_reg.aw_seen && !state_reg.bvalid;
  assign s_axi_wready  = !state_reg.w_seen && !state_reg.bvalid;
  assign s_axi_arready = !state_reg.rvalid;

  // next state: bus slave, register writes and derived port outputs
  always_comb
  begin
    logic [IDX_PORT_W-1:0] wport;
    logic [IDX_LOW_W-1:0]  wlow;
    logic [IDX_PORT_W-1:0] rport;
    logic [IDX_LOW_W-1:0]  rlow;
    logic                  hit;
    logic [7:0]            rbyte;
    logic [IDX_PORT_W:0]   nhost;
    wport      = '0;
    wlow       = '0;
    rport      = '0;
    rlow       = '0;
    hit        = 1'b0;
    rbyte      = 8'h00;
    nhost      = '0;
    state_next = state_reg;

    // capture address and data independently, in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      state_next.aw_seen = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      state_next.w_seen = 1'b1;
      state_next.w_byte = s_axi_wdata[7:0];
      state_next.w_lane = s_axi_wstrb[0];
    end

    // both halves present: perform the write and owe a response
    if (state_reg.aw_seen && state_reg.w_seen && !state_reg.bvalid)
    begin
      wport              = addr_port(state_reg.aw_addr);
      wlow               = addr_low(state_reg.aw_addr);
      state_next.aw_seen = 1'b0;
      state_next.w_seen  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = RESP_SLVERR;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        if (wport == IDX_PORT_W'(p + 1))
        begin
          if (wlow == IDX_CTRL_ZERO)
          begin
            // only the used bits are stored; upper bits are dropped
            state_next.bresp = RESP_OKAY;
            if (state_reg.w_lane)
              state_next.ctrl0[p] = state_reg.w_byte[CTRL0_USED_W-1:0]; // RULE_13
          end
          else if (wlow == IDX_CTRL_ONE)
          begin
            state_next.bresp = RESP_OKAY;
            if (state_reg.w_lane)
              state_next.ctrl1[p] = state_reg.w_byte[CTRL1_USED_W-1:0]; // RULE_13
          end
          else if (wlow == IDX_STATUS)
          begin
            // status is read-only: accept the write and change nothing
            state_next.bresp = RESP_OKAY; // RULE_13
          end
        end
      end
    end

    // write response leaves when the master takes it
    if (state_reg.bvalid && s_axi_bready)
      state_next.bvalid = 1'b0;

    // read: data is registered at the same edge that takes the address
    if (s_axi_arvalid && s_axi_arready)
    begin
      rport = addr_port(s_axi_araddr);
      rlow  = addr_low(s_axi_araddr);
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        if (rport == IDX_PORT_W'(p + 1))
        begin
          if (rlow == IDX_CTRL_ZERO)
          begin
            hit   = 1'b1;
            rbyte = {5'h00, state_reg.ctrl0[p]}; // RULE_13
          end
          else if (rlow == IDX_CTRL_ONE)
          begin
            hit   = 1'b1;
            rbyte = {6'h00, state_reg.ctrl1[p]}; // RULE_13
          end
          else if (rlow == IDX_STATUS)
          begin
            hit = 1'b1;
            if (p < NPHY)
              rbyte = status_byte(1'b1, phy_stat[p], phy_adv_pause[p],
                                  mac_ctl_zero, mac_ctl_one);
            else
              rbyte = status_byte(1'b0, '0, 2'h0, mac_ctl_zero, mac_ctl_one);
          end
        end
      end
      state_next.rvalid = 1'b1;
      state_next.rdata  = {24'h000000, rbyte};
      state_next.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (state_reg.rvalid && s_axi_rready)
    begin
      state_next.rvalid = 1'b0;
    end

    // per-port outputs follow the stored control bits one cycle later
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      state_next.host[p]  = state_reg.ctrl0[p][CTRL0_TAIL_BIT]; // RULE_01
      state_next.queue[p] = queue_of(state_reg.ctrl0[p][CTRL0_SPLIT_LSB +: 2],
                                     pkt_prio[p]);
      nhost = nhost + (IDX_PORT_W + 1)'(state_reg.ctrl0[p][CTRL0_TAIL_BIT]);
    end
    // the device does not arbitrate hosts, it only flags a misconfiguration
    state_next.multi = (nhost > (IDX_PORT_W + 1)'(1)); // RULE_02
  end

  // one register stage for the whole state word; synchronous active-low reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg        <= '0;
      state_reg.ctrl0  <= {NUM_PORTS{CTRL0_RST}};
      state_reg.ctrl1  <= {NUM_PORTS{CTRL1_RST}};
      state_reg.bresp  <= RESP_OKAY;
      state_reg.rresp  <= RESP_OKAY;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // bus outputs straight from the state
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp  = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata  = state_reg.rdata;
  assign s_axi_rresp  = state_reg.rresp;

  // configuration outputs; the core decodes the split and class values
  always_comb
  begin
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      port_cfg[p].tail_tag     = state_reg.ctrl0[p][CTRL0_TAIL_BIT];           // RULE_01
      port_cfg[p].queue_split  = pos_split_e'(state_reg.ctrl0[p][1:0]);        // RULE_03
      port_cfg[p].stream_class = pos_class_e'(state_reg.ctrl1[p][CTRL1_CLASS_LSB +: 2]); // RULE_05
    end
  end

  assign egress_queue    = state_reg.queue;
  assign host_port_sel   = state_reg.host;
  assign host_port_multi = state_reg.multi;

endmodule

// >>> src/pos_sync.sv
// two-flop synchroniser for a bundle of slow asynchronous levels
module pos_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // both stages kept in one state word
  typedef struct packed {
    logic [W-1:0] meta;   // first stage, read only by the second
    logic [W-1:0] stable; // second stage, safe to use
  } pos_sync_s;

  pos_sync_s state_reg;
  pos_sync_s state_next;

  // shift the pin values through two stages
  always_comb
  begin
    state_next        = state_reg;
    state_next.meta   = d;
    state_next.stable = state_reg.meta;
  end

  // synchronous reset clears both stages
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign q = state_reg.stable;

endmodule
